// file: hdl/dmact_core.v
/*
 * DMA controller core: initialization loads, bus acquisition, priority
 * auction, 3-bit state counter, counters, data channel and termination.
 * Assumes bus pins arrive asynchronously and are synchronised here; a load
 * with the task control block select stores no word and only clears the flags and end_interrupt.
 */
`timescale 1ns/10ps
`include "dmact_map.vh"

module dmact_core (
    input  wire        clk,
    input  wire        reset,
    input  wire        load_strobe,
    input  wire [1:0]  load_select,
    input  wire [15:0] load_data,
    input  wire        go,
    input  wire        error_detect,
    input  wire        periph_valid,
    output wire        periph_ready,
    input  wire [15:0] periph_data,
    input  wire        halt_granted_n,
    input  wire        memory_accept_n,
    input  wire        power_loss_alarm_n,
    input  wire        cpu_variant_strap_n,
    input  wire        priority_chain_in_n,
    output reg         priority_chain_out_n,
    output wire        stop_request_n,
    output reg         memory_cycle_strobe_n,
    output reg         read_n,
    output reg  [15:0] address_bus,
    output reg         address_oe,
    output reg  [15:0] data_bus,
    output reg         data_oe,
    output reg         low_byte_select_n,
    output reg         end_interrupt,
    output wire [3:0]  status
);

    localparam [2:0] ST_IDLE    = 3'h0;
    localparam [2:0] ST_AUCTION = 3'h1;
    localparam [2:0] ST_ADDR    = 3'h2;
    localparam [2:0] ST_STROBE  = 3'h3;
    localparam [2:0] ST_WAIT    = 3'h4;
    localparam [2:0] ST_UPDATE  = 3'h5;
    localparam [2:0] ST_RELEASE = 3'h6;
    // The ripple window is rounded up to whole clock periods.
    localparam [31:0] AUCTION_WIDE = `DMACT_AUCTION_CYC;
    localparam [3:0]  AUCTION_CYC  = AUCTION_WIDE[3:0];

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers.

    reg         grant_meta;
    reg         grant_sync;
    reg         accept_meta;
    reg         accept_sync;
    reg         power_meta;
    reg         power_sync;
    reg         strap_meta;
    reg         strap_sync;
    reg         prio_meta;
    reg         prio_sync;
    wire        granted    = ~grant_sync;
    wire        accepted   = ~accept_sync;
    wire        power_ok   = power_sync;
    wire        hog_strap  = ~strap_sync;
    wire        has_prio   = ~prio_sync;

    // Bus lines idle high, so reset parks both stages high: no false grant or accept.
    always @(posedge clk) begin
        if (reset) begin
            grant_meta  <= 1'b1;
            grant_sync  <= 1'b1;
            accept_meta <= 1'b1;
            accept_sync <= 1'b1;
            power_meta  <= 1'b1;
            power_sync  <= 1'b1;
            strap_meta  <= 1'b1;
            strap_sync  <= 1'b1;
            prio_meta   <= 1'b1;
            prio_sync   <= 1'b1;
        end else begin
            grant_meta  <= halt_granted_n;
            grant_sync  <= grant_meta;
            accept_meta <= memory_accept_n;
            accept_sync <= accept_meta;
            power_meta  <= power_loss_alarm_n;
            power_sync  <= power_meta;
            strap_meta  <= cpu_variant_strap_n;
            strap_sync  <= strap_meta;
            prio_meta   <= priority_chain_in_n;
            prio_sync   <= prio_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers and data channel.

    reg  [2:0]  mode;
    reg  [15:0] transfer_count;
    reg  [15:0] memory_address_counter;
    reg         active;
    reg         flag_done;
    reg         flag_error;
    reg         flag_power;
    reg  [2:0]  state;
    reg  [3:0]  auction_cnt;
    reg  [15:0] chan [0:`DMACT_BUF_DEPTH-1];
    reg  [2:0]  rd_ptr;
    reg  [2:0]  wr_ptr;
    reg  [2:0]  fill;

    function [2:0] ptr_next;
        input [2:0] p;
        begin
            ptr_next = (p == `DMACT_BUF_DEPTH - 1) ? 3'h0 : p + 3'h1;
        end
    endfunction

    wire chan_full   = (fill == `DMACT_BUF_DEPTH);
    wire chan_empty  = (fill == 3'h0);
    wire write_mode  = mode[`DMACT_MODE_DIR];
    wire byte_mode   = mode[`DMACT_MODE_BYTE];
    wire count_zero  = (transfer_count == 16'h0000);
    // Hog mode only pays off on the slower processor variant, hence the strap.
    wire hog         = mode[`DMACT_MODE_HOG] & hog_strap & active;
    // Write mode empties the channel to memory; read mode fills it from memory.
    wire want_cycle  = active & power_ok & ~count_zero &
                       (write_mode ? ~chan_empty : ~chan_full);
    wire in_cycle    = (state != ST_IDLE);
    wire transfer_done = (state == ST_UPDATE);
    wire periph_take = periph_valid & periph_ready;
    // In read mode the peripheral side is a sink; periph_ready then only flags data.
    assign periph_ready = write_mode ? ~chan_full : ~chan_empty;

    assign stop_request_n = ~(want_cycle | in_cycle | hog);
    assign status = {in_cycle | active, flag_power, flag_error, flag_done};

    ////////////////////////////////////////////////////////////////////////
    // Initialization, counters and termination.

    always @(posedge clk) begin
        if (reset) begin
            mode                   <= `DMACT_MODE_RESET;
            transfer_count         <= `DMACT_COUNT_RESET;
            memory_address_counter <= `DMACT_ADDR_RESET;
            active                 <= 1'b0;
            flag_done              <= 1'b0;
            flag_error             <= 1'b0;
            flag_power             <= 1'b0;
            end_interrupt          <= 1'b0;
        end else begin
            if (load_strobe && !active) begin
                flag_done     <= 1'b0;
                flag_error    <= 1'b0;
                flag_power    <= 1'b0;
                end_interrupt <= 1'b0;
                if (load_select == `DMACT_SEL_MODE) begin
                    mode <= load_data[2:0];
                    memory_address_counter[15] <= load_data[`DMACT_MODE_BYTE];
                end else if (load_select == `DMACT_SEL_COUNT) begin
                    transfer_count <= load_data;
                end else if (load_select == `DMACT_SEL_ADDR) begin
                    memory_address_counter[14:0] <= load_data[14:0];
                end
            end
            if (go && !active && !load_strobe)
                active <= 1'b1;
            if (transfer_done) begin
                transfer_count <= transfer_count - 16'h0001;
                memory_address_counter <= memory_address_counter + 16'h0001;
            end
            // Termination waits for any cycle in flight so the bus ends cleanly.
            if (active && !in_cycle) begin
                if (error_detect) begin
                    flag_error    <= 1'b1;
                    active        <= 1'b0;
                    end_interrupt <= 1'b1;
                end else if (!power_ok) begin
                    flag_power    <= 1'b1;
                    active        <= 1'b0;
                    end_interrupt <= 1'b1;
                end else if (count_zero) begin
                    flag_done     <= 1'b1;
                    active        <= 1'b0;
                    end_interrupt <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data channel.

    // One side fills the channel and the other drains it; the direction picks which.
    wire chan_push = write_mode ? periph_take : transfer_done;
    wire chan_pop  = write_mode ? transfer_done : periph_take;

    always @(posedge clk) begin
        if (reset) begin
            rd_ptr <= 3'h0;
            wr_ptr <= 3'h0;
            fill   <= 3'h0;
        end else begin
            if (chan_push) begin
                chan[wr_ptr] <= write_mode ? periph_data : data_bus;
                wr_ptr       <= ptr_next(wr_ptr);
            end
            if (chan_pop)
                rd_ptr <= ptr_next(rd_ptr);
            if (chan_push && !chan_pop)
                fill <= fill + 3'h1;
            else if (chan_pop && !chan_push)
                fill <= fill - 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State counter: auction, address setup, strobe, wait, update, release.

    wire start_cycle = want_cycle & granted & ~accepted;

    always @(posedge clk) begin
        if (reset) begin
            state       <= ST_IDLE;
            auction_cnt <= 4'h0;
        end else begin
            case (state)
            ST_IDLE: begin
                if (start_cycle) begin
                    state       <= ST_AUCTION;
                    auction_cnt <= 4'h0;
                end
            end
            ST_AUCTION: begin
                // A higher controller holds the chain: drop out, the request stays pending.
                if (!has_prio)
                    state <= ST_IDLE;
                else if (auction_cnt == AUCTION_CYC - 4'h1)
                    state <= ST_ADDR;
                else
                    auction_cnt <= auction_cnt + 4'h1;
            end
            ST_ADDR: begin
                state <= ST_STROBE;
            end
            ST_STROBE: begin
                state <= ST_WAIT;
            end
            ST_WAIT: begin
                if (accepted)
                    state <= ST_UPDATE;
            end
            ST_UPDATE: begin
                state <= ST_RELEASE;
            end
            default: begin
                // The memory clears its accept on strobe removal before the next auction.
                if (!accepted)
                    state <= ST_IDLE;
            end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Priority chain.

    always @(posedge clk) begin
        if (reset) begin
            priority_chain_out_n <= 1'b0;
        end else if (state == ST_IDLE) begin
            if (start_cycle)
                priority_chain_out_n <= 1'b1;
            else
                priority_chain_out_n <= hog | ~has_prio;
        end else if (state == ST_AUCTION && !has_prio) begin
            priority_chain_out_n <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus gating decoded from the state counter.

    always @(posedge clk) begin
        if (reset) begin
            memory_cycle_strobe_n <= 1'b1;
            read_n                <= 1'b1;
            address_bus           <= 16'h0000;
            address_oe            <= 1'b0;
            data_bus              <= 16'h0000;
            data_oe               <= 1'b0;
            low_byte_select_n     <= 1'b1;
        end else begin
            case (state)
            ST_ADDR: begin
                address_bus <= {1'b0, memory_address_counter[15:1]};
                address_oe  <= 1'b1;
                // Word mode keeps the select high; byte mode uses the LSB.
                low_byte_select_n <= byte_mode ? memory_address_counter[0] : 1'b1;
                read_n <= write_mode;
            end
            ST_STROBE: begin
                memory_cycle_strobe_n <= 1'b0;
                data_bus <= chan[rd_ptr];
                data_oe  <= write_mode;
            end
            ST_WAIT: begin
                if (accepted) begin
                    memory_cycle_strobe_n <= 1'b1;
                    address_oe <= 1'b0;
                    data_oe    <= 1'b0;
                end
            end
            ST_RELEASE: begin
                read_n <= 1'b1;
            end
            default: begin
                read_n <= read_n;
            end
            endcase
        end
    end

endmodule

// file: pkg/dmact_map.vh
/*
 * Register field positions, reset values and timing counts for the DMA
 * controller core. Assumes a 40 MHz system clock; included by the core.
 */
`ifndef DMACT_MAP_VH
`define DMACT_MAP_VH
// Programmed I/O load selects.
`define DMACT_SEL_MODE      2'h0
`define DMACT_SEL_COUNT     2'h1
`define DMACT_SEL_ADDR      2'h2
`define DMACT_SEL_TCB       2'h3
// Mode register fields.
`define DMACT_MODE_DIR      0
`define DMACT_MODE_BYTE     1
`define DMACT_MODE_HOG      2
`define DMACT_MODE_RESET    3'h0
// Status fields.
`define DMACT_ST_DONE       0
`define DMACT_ST_ERROR      1
`define DMACT_ST_POWER      2
`define DMACT_ST_BUSY       3
// Counter reset values.
`define DMACT_COUNT_RESET   16'h0000
`define DMACT_ADDR_RESET    16'h0000
// Timing: clock period and auction ripple window, both in ns.
`define DMACT_CLK_NS        25
`define DMACT_AUCTION_NS    200
`define DMACT_AUCTION_CYC   ((`DMACT_AUCTION_NS + `DMACT_CLK_NS - 1) / `DMACT_CLK_NS)
// Data channel depth, covering worst-case grant latency.
`define DMACT_BUF_DEPTH     5
`endif

// file: tb/dmact_bus_partner.sv
/* Processor and memory model on the far side of the bus.
   Assumes the core's clock; slow stretches acceptance only, grant always follows one clock later. */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////
module dmact_bus_partner (
    input wire clk,
    input wire reset,
    input wire slow,
    input wire stop_request_n,
    input wire memory_cycle_strobe_n,
    output reg halt_granted_n,
    output reg memory_accept_n
);
    int wait_cnt;
    always @(posedge clk) begin
        if (reset) begin
            halt_granted_n <= 1'b1;
            memory_accept_n <= 1'b1;
            wait_cnt <= 0;
        end else begin
            halt_granted_n <= stop_request_n;
            if (memory_cycle_strobe_n) begin
                memory_accept_n <= 1'b1; // Pulled-up line returns high with the strobe.
                wait_cnt <= 0;
            end else if (wait_cnt >= (slow ? 6 : 1)) begin
                memory_accept_n <= 1'b0;
            end else begin
                wait_cnt <= wait_cnt + 1;
            end
        end
    end
endmodule

// file: tb/dmact_core_sva.sv
/* Port checker for the DMA controller core.
   Assumes the core's single clock and synchronous active-high reset. */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////
module dmact_core_sva (
    input wire        clk,
    input wire        reset,
    input wire        priority_chain_out_n,
    input wire        stop_request_n,
    input wire        memory_cycle_strobe_n,
    input wire        memory_accept_n,
    input wire        power_loss_alarm_n,
    input wire        read_n,
    input wire [15:0] address_bus,
    input wire        address_oe,
    input wire        data_oe,
    input wire        low_byte_select_n,
    input wire        end_interrupt,
    input wire [3:0]  status
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    chk_auction_hold:
        assert property ($rose(priority_chain_out_n) |-> memory_cycle_strobe_n [*8]) else $error("early strobe");
    chk_strobe_release:
        assert property ((!memory_accept_n) [*5] |-> memory_cycle_strobe_n) else $error("strobe held");
    chk_power_no_req:
        assert property ((!power_loss_alarm_n) [*5] ##0 stop_request_n |=> stop_request_n) else $error("new request");
    chk_int_frees_bus:
        assert property (end_interrupt |-> stop_request_n) else $error("bus kept after end");
    chk_int_cause:
        assert property (end_interrupt |-> status[2:0] != 3'h0) else $error("no cause flag");
    chk_word_select:
        assert property (address_oe && !address_bus[14] |-> low_byte_select_n) else $error("byte select low");
    chk_write_dir:
        assert property (data_oe |-> read_n) else $error("data driven on read");
    chk_strobe_prio:
        assert property (!memory_cycle_strobe_n |-> priority_chain_out_n) else $error("priority open");
    chk_addr_steady:
        assert property (!memory_cycle_strobe_n |-> address_oe && $stable(address_bus)) else $error("address moved");
endmodule
////////////////////////////////////////////////////////////////////////
bind dmact_core dmact_core_sva chk_u (.clk, .reset, .priority_chain_out_n, .stop_request_n,
    .memory_cycle_strobe_n, .memory_accept_n, .power_loss_alarm_n, .read_n, .address_bus,
    .address_oe, .data_oe, .low_byte_select_n, .end_interrupt, .status);

// file: tb/tb.sv
/* Self-checking bench for the DMA controller core.
   Assumes the bus partner model and the bound port checker. */
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
    $display("MISMATCH t=%0t got %h want %h", $time, a, e); end end
////////////////////////////////////////////////////////////////////////
module tb;
    reg         clk = 0, reset = 1, load_strobe = 0, go = 0, error_detect = 0, periph_valid = 0, slow = 0;
    reg         power_loss_alarm_n = 1, cpu_variant_strap_n = 1, priority_chain_in_n = 0, acc_q = 1;
    reg         cap_clr = 0;
    reg  [1:0]  load_select = 0;
    reg  [15:0] load_data = 0, periph_data = 0, cap_addr [0:7], cap_data [0:7];
    reg         cap_lsb [0:7], cap_rd [0:7];
    wire        halt_granted_n, memory_accept_n, periph_ready, priority_chain_out_n, stop_request_n;
    wire        memory_cycle_strobe_n, read_n, address_oe, data_oe, low_byte_select_n, end_interrupt;
    wire [15:0] address_bus, data_bus;
    wire [3:0]  status;
    int         n_fail = 0, compares = 0, n_str = 0;
    always #12.5 clk = ~clk;
    dmact_core dut_u (.clk, .reset, .load_strobe, .load_select, .load_data, .go, .error_detect,
        .periph_valid, .periph_ready, .periph_data, .halt_granted_n, .memory_accept_n,
        .power_loss_alarm_n, .cpu_variant_strap_n, .priority_chain_in_n, .priority_chain_out_n,
        .stop_request_n, .memory_cycle_strobe_n, .read_n, .address_bus, .address_oe, .data_bus,
        .data_oe, .low_byte_select_n, .end_interrupt, .status);
    dmact_bus_partner mem_u (.clk, .reset, .slow, .stop_request_n, .memory_cycle_strobe_n,
        .halt_granted_n, .memory_accept_n);
    // Each transfer is recorded when memory first accepts it.
    always @(posedge clk) begin
        acc_q <= memory_accept_n;
        if (cap_clr) begin
            n_str <= 0;
        end else if (acc_q && !memory_accept_n && n_str < 8) begin
            cap_addr[n_str] <= address_bus;
            cap_data[n_str] <= data_bus;
            cap_lsb[n_str] <= low_byte_select_n;
            cap_rd[n_str] <= read_n;
            n_str <= n_str + 1;
        end
    end
    task load(input [1:0] s, input [15:0] d); begin
        @(negedge clk); load_strobe = 1; load_select = s; load_data = d;
        @(negedge clk); load_strobe = 0;
    end endtask
    task push(input [15:0] d); begin
        @(negedge clk); periph_valid = 1; periph_data = d;
        do @(posedge clk); while (periph_ready !== 1'b1);
        @(negedge clk); periph_valid = 0;
    end endtask
    task start(input [15:0] m, input [15:0] c, input [15:0] a); begin
        cap_clr = 1;
        load(0, m);
        cap_clr = 0;
        load(1, c);
        load(2, a);
    end endtask
    // Pulses go and waits for the end; pf drops power after the first transfer.
    task run(input int pf); int i; begin
        @(negedge clk); go = 1;
        @(negedge clk); go = 0;
        for (i = 0; i < 3000 && end_interrupt !== 1'b1; i++) begin
            if (pf != 0 && n_str > 0) power_loss_alarm_n = 0;
            @(negedge clk);
        end
    end endtask
    task finish_test; begin
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end endtask
    initial begin
        #1000000;
        n_fail++;
        finish_test;
    end
    initial begin
        int i;
        repeat (8) @(negedge clk);
        reset = 0;
        start(16'h0001, 16'h0003, 16'h0010);
        for (i = 0; i < 3; i++) push(16'h1234 + i * 16'h4444);
        run(0);
        `CHK(n_str, 3)
        for (i = 0; i < 3; i++) `CHK(cap_data[i], 16'h1234 + i * 16'h4444)
        `CHK(cap_rd[0], 1'b1)
        `CHK(cap_lsb[2], 1'b1)
        `CHK(status, 4'h1)
        `CHK(stop_request_n, 1'b1)
        $display("test word_write done");
        slow = 1;
        start(16'h0002, 16'h0003, 16'h0004);
        periph_valid = 1;
        run(0);
        periph_valid = 0;
        slow = 0;
        `CHK(n_str, 3)
        `CHK(cap_addr[0], 16'h4002)
        `CHK(cap_addr[2], 16'h4003)
        for (i = 0; i < 3; i++) `CHK(cap_lsb[i], i[0])
        `CHK(cap_rd[0], 1'b0)
        `CHK(status, 4'h1)
        $display("test byte_read done");
        start(16'h0001, 16'h0005, 16'h0020);
        push(16'h0f0f);
        error_detect = 1;
        run(0);
        error_detect = 0;
        `CHK(status, 4'h2)
        `CHK(end_interrupt, 1'b1)
        load(3, 16'h0000);
        `CHK(end_interrupt, 1'b0)
        `CHK(status, 4'h0)
        $display("test error_end done");
        start(16'h0001, 16'h0004, 16'h0030);
        push(16'h0001);
        push(16'h0002);
        run(1);
        `CHK(status, 4'h4)
        `CHK(n_str < 4, 1'b1)
        `CHK(stop_request_n, 1'b1)
        power_loss_alarm_n = 1;
        $display("test power_loss done");
        reset = 1;
        repeat (3) @(negedge clk);
        reset = 0;
        `CHK(status, 4'h0)
        `CHK(end_interrupt, 1'b0)
        cpu_variant_strap_n = 0;
        start(16'h0005, 16'h0002, 16'h0040);
        push(16'h0abc);
        @(negedge clk); go = 1;
        @(negedge clk); go = 0;
        repeat (80) @(negedge clk);
        `CHK(n_str, 1)
        `CHK(stop_request_n, 1'b0)
        `CHK(priority_chain_out_n, 1'b1)
        push(16'h0def);
        run(0);
        `CHK(status, 4'h1)
        cpu_variant_strap_n = 1;
        $display("test hog_hold done");
        priority_chain_in_n = 1;
        start(16'h0001, 16'h0001, 16'h0050);
        push(16'h0123);
        @(negedge clk); go = 1;
        @(negedge clk); go = 0;
        repeat (80) @(negedge clk);
        `CHK(n_str, 0)
        `CHK(stop_request_n, 1'b0)
        `CHK(status[3], 1'b1)
        priority_chain_in_n = 0;
        run(0);
        `CHK(n_str, 1)
        `CHK(status, 4'h1)
        $display("test auction_loss done");
        finish_test;
    end
endmodule
